// ### design/sample_fifo_status_flags.sv
`timescale 1ns/1ps
// Contract
// RULE1 - A stored result of a checked channel at or below the lower limit sets the below flag.
// RULE2 - The below-limit flag holds until the queue is emptied, then clears.
// RULE3 - Each flag has an interrupt line that rises and falls exactly with it.
// RULE4 - In watermark mode a write to a full queue is dropped and overrun flag bit 2 is set.
// RULE5 - In streaming mode a write to a full queue evicts the oldest entry and sets overrun.
// RULE6 - The overrun flag holds until the queue is emptied, then clears.
// RULE7 - The watermark flag is 1 while the stored count is at or above the programmed watermark.
// RULE8 - The watermark flag is 0 while the stored count is below the programmed watermark.
// RULE9 - The empty flag is set when the queue becomes empty.
// RULE10 - Empty flag is 0 with any entry; 1 after enable, last read, clear, and while disabled.
// RULE11 - The lower limit is 12 bits, bits 11 to 0 of the threshold settings, reset to zero.
// RULE12 - Flags are read-only and leave reset at their defaults.

module sample_fifo_status_flags
  import sample_fifo_pkg::*;
(
  // Clock and reset
  input  wire logic                                   i_core_clk,
  input  wire logic                                   i_rst_n,
  // Queue control
  input  wire logic                                   i_queue_enable,
  input  wire logic                                   i_stream_mode,
  input  wire logic                                   i_queue_clear,
  input  wire logic [sample_fifo_pkg::WM_W-1:0]       i_watermark,
  // Threshold settings
  input  wire logic [sample_fifo_pkg::LIMIT_W-1:0]    i_lower_limit_value,
  input  wire logic [sample_fifo_pkg::CHAN_N-1:0]     i_channel_limit_check_enable,
  // Conversion results in
  input  wire logic                                   i_wr_valid,
  input  wire logic [sample_fifo_pkg::DATA_W-1:0]     i_wr_data,
  input  wire logic [sample_fifo_pkg::CHAN_W-1:0]     i_wr_channel,
  // Host read path
  input  wire logic                                   i_rd_req,
  output logic      [sample_fifo_pkg::DATA_W-1:0]     o_rd_data,
  output logic                                        o_rd_valid,
  // Status and interrupt conditions
  output logic      [sample_fifo_pkg::FLAGS_W-1:0]    o_queue_flags,
  output logic                                        o_irq_empty,
  output logic                                        o_irq_watermark,
  output logic                                        o_irq_overrun,
  output logic                                        o_irq_below_limit
);

  import sample_fifo_pkg::*;

  // ***********************************************
  // Helpers
  // ***********************************************
  function automatic logic [CNT_W-1:0] wm_level(input logic [WM_W-1:0] f);
    wm_level = (f == '0) ? FULL_CNT : {1'b0, f};
  endfunction : wm_level

  function automatic logic at_or_below(input logic [DATA_W-1:0] d,
                                       input logic [LIMIT_W-1:0] lim);
    at_or_below = (d[CMP_HI:CMP_LO] <= lim);
  endfunction : at_or_below

  // ***********************************************
  // State
  // ***********************************************
  logic [PTR_W-1:0]  wr_ptr_r;
  logic [PTR_W-1:0]  rd_ptr_r;
  logic [CNT_W-1:0]  count_r;
  logic              empty_r;
  logic              watermark_r;
  logic              overrun_r;
  logic              below_r;
  logic              rd_valid_r;

  // ***********************************************
  // Decode
  // ***********************************************
  wire               flush     = i_queue_clear | ~i_queue_enable;
  wire               full      = (count_r == FULL_CNT);
  wire               rd_do     = i_rd_req & (count_r != '0) & ~flush;
  wire               wr_in     = i_wr_valid & ~flush;
  // Watermark mode: a read in the same cycle frees the slot
  wire               wr_drop   = wr_in & full & ~i_stream_mode & ~rd_do;       // [RULE4]
  // Streaming mode: oldest entry evicted in place
  wire               wr_evict  = wr_in & full & i_stream_mode & ~rd_do;        // [RULE5]
  wire               wr_do     = wr_in & ~wr_drop;
  wire               rd_adv    = rd_do | wr_evict;
  wire               overflow  = wr_drop | wr_evict;
  wire               below_hit = wr_do & i_channel_limit_check_enable[i_wr_channel]
                                 & at_or_below(i_wr_data, i_lower_limit_value); // [RULE1] [RULE11]

  logic [CNT_W-1:0]  count_nxt;
  always_comb
  begin
    count_nxt = count_r;
    if (flush)
    begin
      count_nxt = '0;
    end
    else if (wr_do && !rd_adv)
    begin
      count_nxt = count_r + CNT_W'(1);
    end
    else if (rd_do && !wr_do)
    begin
      count_nxt = count_r - CNT_W'(1);
    end
  end

  wire               empty_nxt     = (count_nxt == '0);                       // [RULE9] [RULE10]
  wire               watermark_nxt = (count_nxt >= wm_level(i_watermark));   // [RULE7] [RULE8]
  // Set wins: a new event in the emptying cycle is still reported
  wire               overrun_nxt   = overflow | (overrun_r & ~empty_nxt);     // [RULE6]
  wire               below_nxt     = below_hit | (below_r & ~empty_nxt);      // [RULE2]

  // ***********************************************
  // Storage
  // ***********************************************
  sample_store u_store (
    .i_core_clk (i_core_clk),
    .i_we       (wr_do),
    .i_waddr    (wr_ptr_r),
    .i_wdata    (i_wr_data),
    .i_re       (rd_do),
    .i_raddr    (rd_ptr_r),
    .o_rdata    (o_rd_data)
  );

  // ***********************************************
  // Registers
  // ***********************************************
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
      rd_valid_r <= 1'b0;
    end
    else if (flush)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
      rd_valid_r <= 1'b0;
    end
    else
    begin
      if (wr_do)
      begin
        wr_ptr_r <= wr_ptr_r + PTR_W'(1);
      end
      if (rd_adv)
      begin
        rd_ptr_r <= rd_ptr_r + PTR_W'(1);
      end
      count_r    <= count_nxt;
      rd_valid_r <= rd_do;
    end
  end

  // Flags have no write path at all
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      empty_r     <= RST_EMPTY;                                                // [RULE12]
      watermark_r <= RST_WATERMARK;
      overrun_r   <= RST_OVERRUN;
      below_r     <= RST_BELOW;
    end
    else
    begin
      empty_r     <= empty_nxt;
      watermark_r <= watermark_nxt;
      overrun_r   <= overrun_nxt;
      below_r     <= below_nxt;
    end
  end

  // ***********************************************
  // Outputs
  // ***********************************************
  // Interrupt lines are the flag flops themselves, so no skew
  assign o_irq_empty       = empty_r;                                          // [RULE3]
  assign o_irq_watermark   = watermark_r;                                      // [RULE3]
  assign o_irq_overrun     = overrun_r;                                        // [RULE3]
  assign o_irq_below_limit = below_r;                                          // [RULE3]
  assign o_rd_valid        = rd_valid_r;
  assign o_queue_flags     = {4'h0, below_r, overrun_r, watermark_r, empty_r};

  // ***********************************************
  // Checks
  // ***********************************************
  below_set_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE1]
    below_hit |=> below_r)
    else $error("below-limit flag missed a low stored result");

  below_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE2]
    below_r && !empty_nxt |=> below_r)
    else $error("below-limit flag dropped while queue not empty");

  irq_follow_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE3]
    $rose(o_queue_flags[OVERRUN_BIT]) |-> $rose(o_irq_overrun))
    else $error("overrun interrupt not in step with flag");

  drop_keep_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE4]
    wr_drop |=> overrun_r && count_r == FULL_CNT && $stable(wr_ptr_r))
    else $error("watermark-mode overflow did not discard and flag");

  evict_oldest_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE5]
    wr_evict |=> overrun_r && count_r == FULL_CNT
                 && rd_ptr_r == $past(rd_ptr_r) + PTR_W'(1))
    else $error("streaming overflow did not evict oldest entry");

  overrun_clear_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE6]
    overrun_r && empty_nxt && !overflow |=> !overrun_r)
    else $error("overrun flag survived an empty queue");

  wm_track_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE7]
    ##1 (watermark_r == ($past(count_nxt) >= wm_level($past(i_watermark)))))
    else $error("watermark flag disagrees with occupancy");

  empty_track_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE10]
    empty_r == (count_r == '0))
    else $error("empty flag disagrees with occupancy");

  disabled_empty_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE10]
    !i_queue_enable |=> empty_r && !o_rd_valid)
    else $error("empty flag low while queue disabled");

endmodule : sample_fifo_status_flags

// ### design/sample_fifo_pkg.sv
package sample_fifo_pkg;

  // ***********************************************
  // Geometry
  // ***********************************************
  localparam int unsigned DATA_W    = 24;
  localparam int unsigned DEPTH     = 256;
  localparam int unsigned PTR_W     = 8;
  localparam int unsigned CNT_W     = 9;
  localparam int unsigned CHAN_W    = 4;
  localparam int unsigned CHAN_N    = 16;
  localparam int unsigned WM_W      = 8;
  localparam int unsigned LIMIT_W   = 12;
  localparam int unsigned FLAGS_W   = 8;

  // ***********************************************
  // Status flag field positions
  // ***********************************************
  localparam int unsigned EMPTY_BIT     = 0;
  localparam int unsigned WATERMARK_BIT = 1;
  localparam int unsigned OVERRUN_BIT   = 2;
  localparam int unsigned BELOW_BIT     = 3;

  // Compare field of a stored result against the lower limit
  localparam int unsigned CMP_HI = 23;
  localparam int unsigned CMP_LO = 12;

  // ***********************************************
  // Reset values
  // ***********************************************
  localparam logic RST_EMPTY     = 1'b1;
  localparam logic RST_WATERMARK = 1'b0;
  localparam logic RST_OVERRUN   = 1'b0;
  localparam logic RST_BELOW     = 1'b0;
  localparam logic [LIMIT_W-1:0] RST_LOWER_LIMIT = 12'h000;

  // Watermark field value 0 stands for the full depth
  localparam logic [CNT_W-1:0] FULL_CNT = 9'h100;

endpackage : sample_fifo_pkg

// ### design/sample_store.sv
`timescale 1ns/1ps

module sample_store
  import sample_fifo_pkg::*;
(
  // Clock
  input  wire logic                                   i_core_clk,
  // Write port
  input  wire logic                                   i_we,
  input  wire logic [sample_fifo_pkg::PTR_W-1:0]      i_waddr,
  input  wire logic [sample_fifo_pkg::DATA_W-1:0]     i_wdata,
  // Read port
  input  wire logic                                   i_re,
  input  wire logic [sample_fifo_pkg::PTR_W-1:0]      i_raddr,
  output logic      [sample_fifo_pkg::DATA_W-1:0]     o_rdata
);

  logic [DATA_W-1:0] mem_r [DEPTH];

  // No reset on the array so it maps onto block RAM
  always_ff @(posedge i_core_clk)
  begin
    if (i_we)
    begin
      mem_r[i_waddr] <= i_wdata;
    end
    if (i_re)
    begin
      o_rdata <= mem_r[i_raddr];
    end
  end

endmodule : sample_store

// ### verification/host_reader.sv
`timescale 1ns/1ps

module host_reader
  import sample_fifo_pkg::*;
(
  // Clock
  input  wire logic                               i_core_clk,
  // Read path
  output logic                                    o_rd_req,
  input  wire logic                               i_rd_valid,
  input  wire logic [sample_fifo_pkg::DATA_W-1:0] i_rd_data
);
  initial o_rd_req = 1'b0;

  // ***********************************************
  // One read pulse; answer stands one cycle only
  // ***********************************************
  task automatic read(output logic ok, output logic [DATA_W-1:0] d);
    @(posedge i_core_clk);
    #1 o_rd_req = 1'b1;
    @(posedge i_core_clk);
    #1 o_rd_req = 1'b0;
    ok = i_rd_valid;
    d  = i_rd_data;
  endtask : read

endmodule : host_reader

// ### verification/tb_top.sv
`timescale 1ns/1ps

module tb_top;
  import sample_fifo_pkg::*;

  logic               clk = 1'b0;
  logic               rst_n = 1'b0;
  logic               en = 1'b0;
  logic               strm = 1'b0;
  logic               clr = 1'b0;
  logic [WM_W-1:0]    wm = 8'h02;
  logic [LIMIT_W-1:0] lim = 12'h100;
  logic [CHAN_N-1:0]  chen = 16'h0001;
  logic               wv = 1'b0;
  logic [DATA_W-1:0]  wd = 24'h000000;
  logic [CHAN_W-1:0]  wc = 4'h0;
  logic               rreq;
  logic               rv;
  logic [DATA_W-1:0]  rd;
  logic [FLAGS_W-1:0] fl;
  logic [3:0]         irq;
  logic               ok;
  logic [DATA_W-1:0]  d;
  int                 fails = 0;
  int                 check_count = 0;

  sample_fifo_status_flags dut (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_queue_enable(en), .i_stream_mode(strm),
    .i_queue_clear(clr), .i_watermark(wm), .i_lower_limit_value(lim),
    .i_channel_limit_check_enable(chen), .i_wr_valid(wv), .i_wr_data(wd),
    .i_wr_channel(wc), .i_rd_req(rreq), .o_rd_data(rd), .o_rd_valid(rv),
    .o_queue_flags(fl), .o_irq_empty(irq[0]), .o_irq_watermark(irq[1]),
    .o_irq_overrun(irq[2]), .o_irq_below_limit(irq[3]));

  host_reader host (.i_core_clk(clk), .o_rd_req(rreq), .i_rd_valid(rv), .i_rd_data(rd));

  initial forever #10 clk = ~clk;

  // ***********************************************
  // Checking
  // ***********************************************
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Interrupt lines must match the flag bits exactly
  task automatic flags(input logic [7:0] e);
    chk({16'h0, fl}, {16'h0, e});
    chk({20'h0, irq}, {20'h0, e[3:0]});
  endtask : flags

  task automatic wr(input logic [23:0] dv, input logic [3:0] c);
    @(posedge clk);
    #1 wv = 1'b1;
    wd = dv;
    wc = c;
    @(posedge clk);
    #1 wv = 1'b0;
  endtask : wr

  task automatic pulse_clear();
    @(posedge clk);
    #1 clr = 1'b1;
    @(posedge clk);
    #1 clr = 1'b0;
  endtask : pulse_clear

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  // ***********************************************
  // Scenarios
  // ***********************************************
  task automatic t_reset();
    flags(8'h01);
    $display("test reset done");
  endtask : t_reset

  // Limit boundary, disabled channel, watermark tracking, empty read refused
  task automatic t_limit();
    wr(24'h000000, 4'h1);
    flags(8'h00);
    wr(24'h100000, 4'h0);
    flags(8'h0A);
    host.read(ok, d);
    chk({23'h0, ok}, 24'h000001);
    chk(d, 24'h000000);
    flags(8'h08);
    host.read(ok, d);
    chk(d, 24'h100000);
    flags(8'h01);
    host.read(ok, d);
    chk({23'h0, ok}, 24'h0);
    $display("test limit done");
  endtask : t_limit

  // Full queue: new result dropped or oldest evicted
  task automatic t_over(input logic s);
    strm = s;
    wm = 8'h00;
    for (int i = 0; i < 256; i++)
      wr(24'h800000 + 24'(i), 4'h1);
    flags(8'h02);
    wr(24'h8FFFFF, 4'h1);
    flags(8'h06);
    host.read(ok, d);
    chk(d, s ? 24'h800001 : 24'h800000);
    flags(8'h04);
    if (s)
    begin
      @(posedge clk);
      #1 en = 1'b0;
      @(posedge clk);
      #1 en = 1'b1;
    end
    else
      pulse_clear();
    flags(8'h01);
    $display("test overrun mode %0d done", s);
  endtask : t_over

  // Reset in mid-run drops stored state back to defaults
  task automatic t_rerun();
    wr(24'h000000, 4'h0);
    flags(8'h08);
    @(posedge clk);
    #1 rst_n = 1'b0;
    @(posedge clk);
    #1 flags(8'h01);
    rst_n = 1'b1;
    wr(24'h100000, 4'h1);
    flags(8'h00);
    $display("test rerun done");
  endtask : t_rerun

  initial
  begin
    #(200000);
    fails++;
    summarize();
  end

  initial
  begin
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    en = 1'b1;
    t_reset();
    t_limit();
    t_over(1'b0);
    t_over(1'b1);
    t_rerun();
    summarize();
  end

endmodule : tb_top
